// [flash_arb_defines.vh]
// Constants for the flash boot copy engine and user port arbiter
`ifndef FLASH_ARB_DEFINES_VH
`define FLASH_ARB_DEFINES_VH

// ----------------------------------------
// Flash geometry
// ----------------------------------------
`define FA_ADDR_W        17
`define FA_DATA_W        32
`define FA_CLIENTS       64
`define FA_CLIENT_W      6
`define FA_WORDS_W       12

// ----------------------------------------
// Client table field layout
// ----------------------------------------
`define FA_ENT_W         32
`define FA_ENT_BASE_LSB  0
`define FA_ENT_WORDS_LSB 17
`define FA_ENT_SIZE_LSB  29
`define FA_ENT_VALID_BIT 31

// ----------------------------------------
// Word size codes
// ----------------------------------------
`define FA_SIZE_8        2'h0
`define FA_SIZE_16       2'h1
`define FA_SIZE_32       2'h2

// ----------------------------------------
// Cost budget
// ----------------------------------------
`define FA_COST_MAX      7'h40

`endif

// [flash_arb_props.sv]
// Port checks for the boot copy engine arbiter
`timescale 1ns/1ps
`default_nettype none
module flash_arb_props (
	input wire logic        clock,              // Clock
	input wire logic        rst_b,              // Reset
	input wire logic        save_req,           // Save
	input wire logic        usr_req,            // User req
	input wire logic [16:0] usr_addr,           // User addr
	input wire logic        usr_ack,            // User ack
	input wire logic        copy_complete_flag, // Idle
	input wire logic        cfg_error,          // Fault
	input wire logic        flash_req,          // Flash req
	input wire logic        flash_ack,          // Flash ack
	input wire logic [16:0] flash_addr,         // Flash addr
	input wire logic        client_en,          // Client write
	input wire logic        client_save         // Client read
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	// User request taken while idle
	sequence user_take_s;
		copy_complete_flag && usr_req && !save_req && !flash_req && !usr_ack;
	endsequence
	// Save request taken while idle
	sequence save_take_s;
		copy_complete_flag && save_req;
	endsequence
	user_fwd_a: assert property (user_take_s |=> flash_req && flash_addr == $past(usr_addr))
		else $error("user request not forwarded");
	busy_no_ack_a: assert property (usr_ack |-> copy_complete_flag)
		else $error("user ack while engine busy");
	ack_source_a: assert property (usr_ack |-> $past(flash_ack))
		else $error("user ack without flash ack");
	ack_follow_a: assert property (copy_complete_flag && flash_ack && !save_req |=> usr_ack)
		else $error("flash ack not passed to user");
	flash_hold_a: assert property (flash_req && !flash_ack |=> flash_req && $stable(flash_addr))
		else $error("flash request dropped early");
	save_take_a: assert property (save_take_s |=> !copy_complete_flag [*2])
		else $error("save not accepted");
	engine_strobe_a: assert property (client_en || client_save |-> !copy_complete_flag)
		else $error("client strobe while idle");
	err_sticky_a: assert property (cfg_error |=> cfg_error)
		else $error("config fault cleared");
endmodule
bind flash_init_user_arbiter flash_arb_props i_props (.clock, .rst_b, .save_req, .usr_req, .usr_addr, .usr_ack,
	.copy_complete_flag, .cfg_error, .flash_req, .flash_ack, .flash_addr, .client_en, .client_save);
`default_nettype wire

// [flash_block_model.sv]
// Behavioural flash block facing the arbiter
`timescale 1ns/1ps
`default_nettype none
module flash_block_model (
	input  wire logic        clock,             // Clock
	input  wire logic        slow,              // Stretch answers
	input  wire logic        flash_req,         // Request
	input  wire logic [16:0] flash_addr,        // Address
	output var  logic        flash_ack = 1'b0,  // Done pulse
	output var  logic [31:0] flash_rdata = '0   // Read data
);
	logic [3:0] wait_q = 4'h0; // Cycles waited
	// Ack after 0 or 5 waits; data toggles outside the ack cycle
	always @(posedge clock) begin
		flash_ack <= 1'b0;
		flash_rdata <= ~flash_rdata;
		if (flash_req && !flash_ack) begin
			if (wait_q >= (slow ? 4'h5 : 4'h0)) begin
				flash_ack <= 1'b1;
				flash_rdata <= 32'hC3000000 | {15'h0, flash_addr};
				wait_q <= 4'h0;
			end else begin
				wait_q <= wait_q + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// [flash_init_user_arbiter.v]
// Boot copy engine with user port arbitration on a shared flash block
// Function
// R1 - Power-up request copies flash into all clients
// R2 - Engine activity owns flash, user loses
// R3 - User never triggers engine during own access
// R4 - User checks complete flag before access
// R5 - Save request held until flag drops
// R6 - Shared clock must stay below 100 MHz
// R7 - Cascaded RAM uses one client per block
// R8 - Client word width is 8, 16, 32
// R9 - Total client cost at most 64
// R10 - No user forwarding or ack while engine owns
`timescale 1ns/1ps
`default_nettype none
`include "flash_arb_defines.vh"

module flash_init_user_arbiter (
	input  wire                         clock,          // System clock, below 100 MHz in the system
	input  wire                         rst_b,          // Async reset, low = power-up request
	input  wire [`FA_ENT_W*`FA_CLIENTS-1:0] client_table, // Per-client base, words, size, valid
	input  wire                         save_req,       // On-demand save request, level
	input  wire                         usr_req,        // User access request
	input  wire                         usr_we,         // User write
	input  wire [`FA_ADDR_W-1:0]        usr_addr,       // User address
	input  wire [`FA_DATA_W-1:0]        usr_wdata,      // User write data
	output reg                          usr_ack,        // User access done
	output reg  [`FA_DATA_W-1:0]        usr_rdata,      // User read data
	output reg                          copy_complete_flag, // Engine idle, copy done
	output reg                          cfg_error,      // Bad width or cost over budget
	output reg                          flash_req,      // Flash block request
	output reg                          flash_we,       // Flash block write
	output reg  [`FA_ADDR_W-1:0]        flash_addr,     // Flash block address
	output reg  [`FA_DATA_W-1:0]        flash_wdata,    // Flash block write data
	input  wire                         flash_ack,      // Flash block done
	input  wire [`FA_DATA_W-1:0]        flash_rdata,    // Flash block read data
	output reg                          client_en,      // Client write strobe
	output reg                          client_save,    // Client read strobe for save
	output reg  [`FA_CLIENT_W-1:0]      client_sel,     // Selected client
	output reg  [`FA_WORDS_W-1:0]       client_addr,    // Word address in client
	output reg  [`FA_DATA_W-1:0]        client_wdata,   // Data to client
	input  wire [`FA_DATA_W-1:0]        client_rdata    // Data from client
);

	// ----------------------------------------
	// States
	// ----------------------------------------
	localparam [2:0] ST_IDLE  = 3'h0; // User owns flash
	localparam [2:0] ST_ENTRY = 3'h1; // Fetch client entry
	localparam [2:0] ST_CHECK = 3'h2; // Validate client
	localparam [2:0] ST_FLASH = 3'h3; // Flash access in flight
	localparam [2:0] ST_CLWR  = 3'h4; // Client strobe
	localparam [2:0] ST_NEXT  = 3'h5; // Advance word or client
	localparam [2:0] ST_USER  = 3'h6; // User access in flight

	reg  [2:0]              state_q;   // Current state
	reg                     saving_q;  // Operation is a save
	reg  [`FA_CLIENT_W-1:0] idx_q;     // Client index
	reg  [`FA_WORDS_W-1:0]  word_q;    // Word index
	reg  [6:0]              cost_q;    // Accumulated cost
	wire [`FA_ENT_W-1:0]    entry;     // Current client entry

	wire [`FA_ADDR_W-1:0]   ent_base  = entry[`FA_ENT_BASE_LSB +: `FA_ADDR_W];
	wire [`FA_WORDS_W-1:0]  ent_words = entry[`FA_ENT_WORDS_LSB +: `FA_WORDS_W];
	wire [1:0]              ent_size  = entry[`FA_ENT_SIZE_LSB +: 2];
	wire                    ent_valid = entry[`FA_ENT_VALID_BIT];

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Byte address of a word in flash, by word size
	function [`FA_ADDR_W-1:0] word_addr;
		input [`FA_ADDR_W-1:0]  base;
		input [`FA_WORDS_W-1:0] w;
		input [1:0]             sz;
		begin
			case (sz)
				`FA_SIZE_16: word_addr = base + {4'h0, w, 1'b0};
				`FA_SIZE_32: word_addr = base + {3'h0, w, 2'b00};
				default:     word_addr = base + {5'h00, w};
			endcase
		end
	endfunction

	// Mask data to the client word width
	function [`FA_DATA_W-1:0] size_mask;
		input [`FA_DATA_W-1:0] d;
		input [1:0]            sz;
		begin
			case (sz)
				`FA_SIZE_16: size_mask = {16'h0000, d[15:0]};
				`FA_SIZE_32: size_mask = d;
				default:     size_mask = {24'h000000, d[7:0]};
			endcase
		end
	endfunction

	// ----------------------------------------
	// Client table
	// ----------------------------------------
	flash_table_rom u_table (
		.clock      (clock),
		.index      (idx_q),
		.table_flat (client_table),
		.entry_q    (entry)
	);

	// ----------------------------------------
	// Engine and arbiter
	// ----------------------------------------
	always @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			// R1 - reset starts copy
			state_q            <= ST_ENTRY;
			saving_q           <= 1'b0;
			idx_q              <= {`FA_CLIENT_W{1'b0}};
			word_q             <= {`FA_WORDS_W{1'b0}};
			cost_q             <= 7'h00;
			copy_complete_flag <= 1'b0;
			cfg_error          <= 1'b0;
			usr_ack            <= 1'b0;
			usr_rdata          <= 32'h00000000;
			flash_req          <= 1'b0;
			flash_we           <= 1'b0;
			flash_addr         <= {`FA_ADDR_W{1'b0}};
			flash_wdata        <= 32'h00000000;
			client_en          <= 1'b0;
			client_save        <= 1'b0;
			client_sel         <= {`FA_CLIENT_W{1'b0}};
			client_addr        <= {`FA_WORDS_W{1'b0}};
			client_wdata       <= 32'h00000000;
		end else begin
			usr_ack     <= 1'b0;
			client_en   <= 1'b0;
			client_save <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					// R5 - save accepted, flag drops
					if (save_req) begin
						saving_q           <= 1'b1;
						idx_q              <= {`FA_CLIENT_W{1'b0}};
						word_q             <= {`FA_WORDS_W{1'b0}};
						cost_q             <= 7'h00;
						copy_complete_flag <= 1'b0;
						state_q            <= ST_ENTRY;
					end else if (usr_req) begin
						// R10 - forward only when idle
						flash_req   <= 1'b1;
						flash_we    <= usr_we;
						flash_addr  <= usr_addr;
						flash_wdata <= usr_wdata;
						state_q     <= ST_USER;
					end
				end
				ST_USER: begin
					if (flash_ack) begin
						flash_req <= 1'b0;
						flash_we  <= 1'b0;
						usr_ack   <= 1'b1;
						usr_rdata <= flash_rdata;
						state_q   <= ST_IDLE;
					end
				end
				ST_ENTRY: begin
					// Table read latency
					state_q <= ST_CHECK;
				end
				ST_CHECK: begin
					// R7 - cascaded RAM: one entry per block
					// R9 - cost budget of clients
					if (!ent_valid) begin
						state_q <= ST_NEXT;
						word_q  <= ent_words;
					end else if (ent_size > `FA_SIZE_32 || cost_q >= `FA_COST_MAX) begin
						// R8 - reject illegal widths
						cfg_error <= 1'b1;
						state_q   <= ST_NEXT;
						word_q    <= ent_words;
					end else begin
						cost_q     <= cost_q + 7'h01;
						client_sel <= idx_q;
						if (saving_q) begin
							client_save <= 1'b1;
							client_addr <= word_q;
							state_q     <= ST_CLWR;
						end else begin
							flash_req  <= 1'b1;
							flash_we   <= 1'b0;
							flash_addr <= word_addr(ent_base, word_q, ent_size);
							state_q    <= ST_FLASH;
						end
					end
				end
				ST_CLWR: begin
					// Client data sampled in the cycle the strobe is high
					flash_req   <= 1'b1;
					flash_we    <= 1'b1;
					flash_addr  <= word_addr(ent_base, word_q, ent_size);
					flash_wdata <= size_mask(client_rdata, ent_size);
					state_q     <= ST_FLASH;
				end
				ST_FLASH: begin
					// R2 - engine holds flash
					if (flash_ack) begin
						flash_req <= 1'b0;
						flash_we  <= 1'b0;
						if (!saving_q) begin
							client_en    <= 1'b1;
							client_addr  <= word_q;
							client_wdata <= size_mask(flash_rdata, ent_size);
						end
						word_q  <= word_q + 12'h001;
						state_q <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					if (ent_valid && word_q < ent_words && !cfg_error) begin
						if (saving_q) begin
							client_save <= 1'b1;
							client_addr <= word_q;
							state_q     <= ST_CLWR;
						end else begin
							flash_req  <= 1'b1;
							flash_addr <= word_addr(ent_base, word_q, ent_size);
							state_q    <= ST_FLASH;
						end
					end else if (idx_q == 6'h3F) begin
						copy_complete_flag <= 1'b1;
						saving_q           <= 1'b0;
						state_q            <= ST_IDLE;
					end else begin
						idx_q   <= idx_q + 6'h01;
						word_q  <= {`FA_WORDS_W{1'b0}};
						state_q <= ST_ENTRY;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

endmodule
`default_nettype wire

// [flash_init_user_arbiter_tb_top.sv]
// Testbench for the boot copy engine arbiter
`timescale 1ns/1ps
`default_nettype none
module flash_init_user_arbiter_tb_top;
	logic        clock = 0, rst_b = 0, save_req = 0, usr_req = 0, usr_we = 0, slow = 0; // Stimulus
	logic [16:0] usr_addr = 0, flash_addr;                                           // Addresses
	logic [31:0] usr_wdata = 0, client_rdata, usr_rdata, flash_wdata, flash_rdata, client_wdata; // Data
	logic [2047:0] client_table = 0;                                                 // Client table
	logic        usr_ack, copy_complete_flag, cfg_error, flash_req, flash_we, flash_ack, client_en, client_save;
	logic [5:0]  client_sel;                                                         // Client
	logic [11:0] client_addr;                                                        // Word
	logic [49:0] cl_q[$], wr_q[$];                                                   // Seen transfers
	int          errors = 0, total_checks = 0, cyc = 0;                              // Counters
	flash_init_user_arbiter i_dut (.clock, .rst_b, .client_table, .save_req, .usr_req, .usr_we, .usr_addr,
		.usr_wdata, .usr_ack, .usr_rdata, .copy_complete_flag, .cfg_error, .flash_req, .flash_we, .flash_addr,
		.flash_wdata, .flash_ack, .flash_rdata, .client_en, .client_save, .client_sel, .client_addr,
		.client_wdata, .client_rdata);
	flash_block_model i_flash (.clock, .slow, .flash_req, .flash_addr, .flash_ack, .flash_rdata);
	// Clock, 4 ns period
	// one clock shared by engine and user
	initial begin
		forever #2 clock = ~clock;
	end
	// Client data source: read data follows the selected word in the same cycle
	assign client_rdata = 32'hAB000000 | {14'h0, client_sel, client_addr};
	// Transfer monitor and timeout
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (client_en) cl_q.push_back({client_sel, client_addr, client_wdata});
		if (flash_req && flash_we && flash_ack) wr_q.push_back({1'b0, flash_addr, flash_wdata});
		if (cyc == 20000) begin
			errors++;
			wrap_up();
		end
	end
	task automatic chk(string n, logic [49:0] e, logic [49:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wait_flag(logic v);
		for (int i = 0; i < 400 && copy_complete_flag !== v; i++) begin
			@(posedge clock);
			#1;
		end
	endtask
	task automatic t_init(logic [1:0] sz1, logic err);
		client_table = 0;
		client_table[31:0] = {1'b1, 2'h2, 12'd2, 17'h100};
		client_table[63:32] = {1'b1, sz1, 12'd3, 17'h200};
		cl_q.delete();
		rst_b = 0;
		repeat (6) @(posedge clock);
		#1 rst_b = 1;
		wait_flag(1);
		chk("copy_done", 50'd1, 50'(copy_complete_flag));
		chk("cfg_error", 50'(err), 50'(cfg_error));
		if (!err) begin
			chk("copies", 50'd5, 50'(cl_q.size()));
			for (int w = 0; w < 5; w++)
				chk("client", w < 2 ? {6'd0, 12'(w), 32'hC3000100 + 32'(4 * w)} : {6'd1, 12'(w - 2), 32'(w - 2)}, cl_q[w]);
		end
	endtask
	task automatic t_user(logic we, logic [16:0] a, logic [31:0] d);
		// wait for the idle flag first
		wait_flag(1);
		usr_we = we;
		usr_addr = a;
		usr_wdata = d;
		usr_req = 1;
		for (int i = 0; i < 400 && usr_ack !== 1; i++) begin
			@(posedge clock);
			#1;
		end
		usr_req = 0;
		chk("usr_ack", 50'd1, 50'(usr_ack));
		if (!we) chk("usr_rdata", 50'(d), 50'(usr_rdata));
		else chk("flash_write", {1'b0, a, d}, wr_q[$]);
		// Let the ack pulse end before the next request
		@(posedge clock);
		#1;
	endtask
	task automatic t_save();
		wr_q.delete();
		// no access in flight, hold until the flag drops
		save_req = 1;
		wait_flag(0);
		chk("save_taken", 50'd0, 50'(copy_complete_flag));
		save_req = 0;
		usr_addr = 17'h0055;
		usr_we = 0;
		usr_req = 1;
		for (int i = 0; i < 400 && copy_complete_flag !== 1; i++) begin
			@(posedge clock);
			#1;
			if (usr_ack === 1) chk("busy_ack", 50'd0, 50'd1);
		end
		chk("saves", 50'd5, 50'(wr_q.size()));
		for (int w = 0; w < 5; w++)
			chk("save", w < 2 ? {1'b0, 17'h100 + 17'(4 * w), 32'hAB000000 | 32'(w)} : {1'b0, 17'h200 + 17'(w - 2), 32'(w - 2)}, wr_q[w]);
		t_user(0, 17'h0055, 32'hC3000055);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		t_init(2'h0, 0);
		t_user(0, 17'h0ABC, 32'hC3000ABC);
		slow = 1;
		t_user(1, 17'h0123, 32'h5A5A1234);
		t_save();
		t_init(2'h3, 1);
		wrap_up();
	end
endmodule
`default_nettype wire

// [flash_table_rom.v]
// Client table of the boot copy engine
`timescale 1ns/1ps
`default_nettype none
`include "flash_arb_defines.vh"

module flash_table_rom (
	input  wire                       clock,  // System clock
	input  wire [`FA_CLIENT_W-1:0]    index,  // Client index
	input  wire [`FA_ENT_W*`FA_CLIENTS-1:0] table_flat, // Client table contents
	output reg  [`FA_ENT_W-1:0]       entry_q // Registered entry
);

	// ----------------------------------------
	// Table array
	// ----------------------------------------
	wire [`FA_ENT_W-1:0] table_mem [0:`FA_CLIENTS-1]; // Unpacked entries

	genvar g;
	generate
		for (g = 0; g < `FA_CLIENTS; g = g + 1) begin : g_unpack
			assign table_mem[g] = table_flat[g*`FA_ENT_W +: `FA_ENT_W];
		end
	endgenerate

	// Registered read, no reset needed
	always @(posedge clock) begin
		entry_q <= table_mem[index];
	end

endmodule
`default_nettype wire
